// >>> sim/asr_chk_sva.sv
// Purpose: port-level checks for the audio serial receiver
// Assumes: one clock domain, asynchronous active-high reset
// Notes: limit, mask, mode and enable are shadowed from completed APB writes
`timescale 1ns/1ps
module asr_chk
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // APB
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Link clocks and request
  input wire logic SCLK_O,
  input wire logic SCLK_OE_N_O,
  input wire logic LRCLK_OE_N_O,
  input wire logic RX_REQ_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  logic [4:0] lim;
  logic [1:0] im;
  logic [1:0] mode;
  logic en;
  logic done;
  logic rd;
  // Completed transfers
  assign done = PSEL_I && PENABLE_I && PREADY_O;
  assign rd = done && !PWRITE_I;
  // Shadows of written control values
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      lim <= LIMIT_RST;
      im <= 2'h0;
      mode <= MODE_DUAL;
      en <= 1'b0;
    end else if (done && PWRITE_I && !PSLVERR_O) begin
      if (PADDR_I == REG_LIMIT) lim <= PWDATA_I[4:0];
      if (PADDR_I == REG_IM) im <= PWDATA_I[1:0];
      if (PADDR_I == REG_CFG) mode <= PWDATA_I[4:3];
      if (PADDR_I == REG_CTRL) en <= PWDATA_I[0];
    end
  end
  a_ready_wait: assert property ($rose(PENABLE_I) && PSEL_I |-> !PREADY_O ##1 PREADY_O)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready held too long");
  a_err_unmapped: assert property (done && PADDR_I > 12'h020 |-> PSLVERR_O) else $error("no slave error");
  a_oe_pair: assert property (SCLK_OE_N_O == LRCLK_OE_N_O) else $error("clock enables differ");
  a_idle_clock_low: assert property (SCLK_OE_N_O |-> !SCLK_O) else $error("clock out while released");
  a_off_released: assert property (!en && !$past(en) |=> SCLK_OE_N_O) else $error("drives while off");
  a_limit_back: assert property (rd && PADDR_I == REG_LIMIT |-> PRDATA_O == {27'h0, lim})
    else $error("limit readback wrong");
  a_level_range: assert property (rd && PADDR_I == REG_LEVEL |-> PRDATA_O <= 32'h10)
    else $error("level out of range");
  a_quiet_limit: assert property (lim == 5'h10 && $past(lim) == 5'h10 |-> !RX_REQ_O)
    else $error("request at top limit");
  a_mask_gate: assert property (!im[1] && !$past(im[1]) |-> !RX_REQ_O) else $error("masked request");
  a_mis_subset: assert property (rd && PADDR_I == REG_MIS |-> (PRDATA_O[1:0] & ~im) == 2'h0)
    else $error("masked status not masked");
  a_pack8_top: assert property (rd && PADDR_I == REG_DATA && mode == MODE_COMPACT8 |-> PRDATA_O[31:16] == 16'h0)
    else $error("upper half not zero");
  // Main scenarios reached
  c_pop: cover property (rd && PADDR_I == REG_DATA);
  c_req: cover property ($rose(RX_REQ_O));
  c_err: cover property (PSLVERR_O);
endmodule

// >>> sim/asr_codec.sv
// Purpose: far-side audio transmitter making bit clock, word clock and data
// Assumes: the receiver follows these clocks as slave
// Notes: clocks stand still between bursts; idle data shows the inverse level
`timescale 1ns/1ps
module asr_codec
  import asr_pkg::*;
(
  // Link pins
  output logic sclk_o,
  output logic lrclk_o,
  output logic sd_o
);
  logic [31:0] word_q[$];
  // Idle levels
  initial begin
    sclk_o = 1'b0;
    lrclk_o = 1'b0;
    sd_o = 1'b0;
  end
  // Two left bits, a right lead-in slot, queued words, then two closing left bits
  task automatic play(input int wbits, input logic [1:0] fmt, input logic inv);
    logic lvl_q[$];
    logic bit_q[$];
    logic left_lvl;
    left_lvl = (fmt != FMT_STANDARD);
    for (int i = 0; i < wbits + 2; i++) begin
      lvl_q.push_back((i < 2) ? left_lvl : !left_lvl);
      bit_q.push_back(1'b0);
    end
    foreach (word_q[k]) begin
      for (int i = wbits - 1; i >= 0; i--) begin
        lvl_q.push_back(left_lvl ^ k[0]);
        bit_q.push_back(word_q[k][i]);
      end
    end
    lvl_q.push_back(left_lvl);
    lvl_q.push_back(left_lvl);
    bit_q.push_back(1'b0);
    bit_q.push_back(1'b0);
    if (fmt == FMT_STANDARD) bit_q.push_front(1'b0);
    #7;
    for (int i = 0; i < lvl_q.size(); i++) begin
      sclk_o = inv;
      lrclk_o = lvl_q[i];
      sd_o = bit_q[i];
      #160;
      sclk_o = !inv;
      #160;
    end
    sclk_o = inv;
    sd_o = !sd_o;
    word_q = {};
  endtask
endmodule

// >>> sim/test_audio_serial_receive_fifo.sv
// Purpose: self-checking bench for the audio serial receiver
// Assumes: the codec model leads the link except in the clock master test
// Notes: each burst but the one sent while disabled follows a disable, configure, enable sequence
`timescale 1ns/1ps
module test_audio_serial_receive_fifo
  import asr_pkg::*;
;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, a, b;
  logic mclk_ext, mclk_run, sd, c_sclk, c_lrclk, sclk_out, sclk_oe_n, lrclk_out, lrclk_oe_n, rx_req;
  int n_fail, total_checks, cnt, lcnt;
  asr_top i_dut (.CLK_SYS_I(clk_sys), .SYS_RST_I(sys_rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .MCLK_EXT_I(mclk_ext), .SD_I(sd), .SCLK_I(sclk_oe_n ? c_sclk : sclk_out),
    .SCLK_O(sclk_out), .SCLK_OE_N_O(sclk_oe_n), .LRCLK_I(lrclk_oe_n ? c_lrclk : lrclk_out),
    .LRCLK_O(lrclk_out), .LRCLK_OE_N_O(lrclk_oe_n), .RX_REQ_O(rx_req));
  asr_codec i_codec (.sclk_o(c_sclk), .lrclk_o(c_lrclk), .sd_o(sd));
  // Clock and gated external master clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    mclk_ext = 1'b0;
    forever #80 mclk_ext = mclk_run ? ~mclk_ext : mclk_ext;
  end
  // One APB transfer held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk($sformatf("register %h", ad), q, exp);
  endtask
  function automatic logic [31:0] mk(input logic [1:0] f, input logic v, input logic [1:0] m,
      input logic ms, input logic [2:0] ss, input logic [2:0] ws, input logic ext);
    asr_cfg_t c;
    c = '{mclk_ext: ext, wire_size: ws, sample_size: ss, master: ms, mode: m, sclk_invert: v, fmt: f};
    return {19'h0, c};
  endfunction
  function automatic logic [31:0] pat(input int k);
    return 32'h9E3779B9 * (k + 1);
  endfunction
  // Disable, configure, enable
  task automatic setup(input logic [31:0] c);
    wr(REG_CTRL, 32'h0);
    wr(REG_CFG, c);
    wr(REG_CTRL, 32'h1);
  endtask
  task automatic send(input int n, input int bits, input logic [1:0] f, input logic v);
    for (int k = 0; k < n; k++) i_codec.word_q.push_back(pat(k));
    i_codec.play(bits, f, v);
    repeat (8) @(posedge clk_sys);
  endtask
  // Counts changes of the generated clocks over 200 cycles
  task automatic count();
    logic ps;
    logic pl;
    cnt = 0;
    lcnt = 0;
    ps = sclk_out;
    pl = lrclk_out;
    repeat (200) begin
      @(posedge clk_sys);
      if (sclk_out !== ps) cnt++;
      if (lrclk_out !== pl) lcnt++;
      ps = sclk_out;
      pl = lrclk_out;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  // Test sequence
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, mclk_run, n_fail, total_checks} = '0;
    sys_rst = 1'b1;
    a = pat(0);
    b = pat(1);
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc(REG_CFG, 32'h0);
    rdc(REG_LIMIT, 32'h10);
    rdc(REG_LEVEL, 32'h0);
    rdc(REG_STAT, 32'h1);
    rdc(REG_IM, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk("slave error", err_seen, 32'h1);
    rdc(REG_DATA, 32'h0);
    rdc(REG_LEVEL, 32'h0);
    setup(mk(FMT_STANDARD, 1'b0, MODE_DUAL, 1'b0, SIZE_32, SIZE_32, 1'b0));
    wr(REG_LIMIT, 32'h2);
    rdc(REG_LIMIT, 32'h2);
    wr(REG_IM, 32'h3);
    send(4, 32, FMT_STANDARD, 1'b0);
    rdc(REG_LEVEL, 32'h4);
    chk("service request", rx_req, 32'h1);
    rdc(REG_MIS, 32'h2);
    wr(REG_IM, 32'h0);
    rdc(REG_RIS, 32'h2);
    chk("masked request", rx_req, 32'h0);
    rdc(REG_MIS, 32'h0);
    wr(REG_IM, 32'h3);
    rdc(REG_DATA, a);
    rdc(REG_LEVEL, 32'h3);
    rdc(REG_DATA, b);
    rdc(REG_LEVEL, 32'h2);
    rdc(REG_DATA, pat(2));
    rdc(REG_DATA, pat(3));
    rdc(REG_STAT, 32'h1);
    wr(REG_CTRL, 32'h0);
    send(4, 32, FMT_STANDARD, 1'b0);
    rdc(REG_LEVEL, 32'h0);
    for (int f = 0; f < 3; f++) begin
      for (int v = 0; v < 2; v++) begin
        setup(mk(2'(f), 1'(v), MODE_COMPACT16, 1'b0, SIZE_16, SIZE_16, 1'b0));
        send(2, 16, 2'(f), 1'(v));
        rdc(REG_DATA, {b[15:0], a[15:0]});
      end
    end
    setup(mk(FMT_STANDARD, 1'b0, MODE_COMPACT8, 1'b0, SIZE_8, SIZE_8, 1'b0));
    send(2, 8, FMT_STANDARD, 1'b0);
    rdc(REG_DATA, {16'h0, b[7:0], a[7:0]});
    for (int i = 0; i < 5; i++) begin
      cnt = (i == 0) ? 32 : (i == 1) ? 24 : (i == 2) ? 20 : (i == 3) ? 16 : 8;
      setup(mk(FMT_STANDARD, 1'b0, MODE_MONO, 1'b0, 3'(i), 3'(i), 1'b0));
      send(2, cnt, FMT_STANDARD, 1'b0);
      rdc(REG_LEVEL, 32'h2);
      rdc(REG_DATA, a & 32'((33'h1 << cnt) - 33'h1));
    end
    setup(mk(FMT_STANDARD, 1'b0, MODE_MONO, 1'b0, SIZE_16, SIZE_24, 1'b0));
    send(2, 24, FMT_STANDARD, 1'b0);
    rdc(REG_DATA, {16'h0, a[23:8]});
    setup(mk(FMT_STANDARD, 1'b0, MODE_MONO, 1'b0, SIZE_32, SIZE_32, 1'b0));
    wr(REG_LIMIT, 32'h10);
    send(18, 32, FMT_STANDARD, 1'b0);
    rdc(REG_LEVEL, 32'h10);
    rdc(REG_STAT, 32'h2);
    rdc(REG_RIS, 32'h1);
    chk("request at limit", rx_req, 32'h0);
    wr(REG_RIS, 32'h1);
    rdc(REG_RIS, 32'h0);
    for (int k = 0; k < 8; k++) rdc(REG_DATA, pat(2 * k));
    rdc(REG_LEVEL, 32'h0);
    setup(mk(FMT_STANDARD, 1'b0, MODE_DUAL, 1'b1, SIZE_8, SIZE_8, 1'b0));
    count();
    chk("internal clock runs", 32'(cnt > 0), 32'h1);
    setup(mk(FMT_STANDARD, 1'b0, MODE_DUAL, 1'b1, SIZE_8, SIZE_8, 1'b1));
    count();
    chk("clock without source", cnt, 32'h0);
    mclk_run = 1'b1;
    count();
    chk("bit clock runs", 32'(cnt > 0), 32'h1);
    chk("word clock runs", 32'(lcnt > 0), 32'h1);
    chk("clock drive", sclk_oe_n, 32'h0);
    wr(REG_CTRL, 32'h0);
    rdc(REG_CTRL, 32'h0);
    chk("clock released", sclk_oe_n, 32'h1);
    wrap_up();
  end
endmodule
bind asr_top asr_chk i_chk (.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SCLK_O(SCLK_O),
  .SCLK_OE_N_O(SCLK_OE_N_O), .LRCLK_OE_N_O(LRCLK_OE_N_O), .RX_REQ_O(RX_REQ_O));

// >>> src/asr_clkgen.sv
// Purpose: bit clock and word clock generator for clock master mode
// Assumes: tick_i is a one-cycle master clock enable
// Notes: word clock turns on a falling bit clock edge
`timescale 1ns/1ps
module asr_clkgen
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [5:0] wire_bits_i,
  // Generated clocks
  output logic sclk_o,
  output logic lrclk_o
);
  logic [3:0] div;
  logic [5:0] bitcnt;

  // Divide the master clock and frame the words
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= '0;
      bitcnt <= '0;
      sclk_o <= 1'b0;
      lrclk_o <= 1'b0;
    end else if (!run_i) begin
      div <= '0;
      bitcnt <= '0;
      sclk_o <= 1'b0;
      lrclk_o <= 1'b0;
    end else if (tick_i) begin
      if (div == SCLK_HALF_TICKS - 4'h1) begin
        div <= '0;
        sclk_o <= ~sclk_o;
        if (sclk_o) begin
          if (bitcnt == wire_bits_i - 6'h01) begin
            bitcnt <= '0;
            lrclk_o <= ~lrclk_o;
          end else begin
            bitcnt <= bitcnt + 6'h01;
          end
        end
      end else begin
        div <= div + 4'h1;
      end
    end
  end
endmodule

// >>> src/asr_pkg.sv
// Purpose: shared constants and types for the audio serial receive block
// Assumes: APB with 32-bit data, one word per register
// Notes: size codes 0..4 stand for 32, 24, 20, 16 and 8 bits
package asr_pkg;
  // Register byte offsets
  localparam logic [11:0] REG_CFG = 12'h000;
  localparam logic [11:0] REG_CTRL = 12'h004;
  localparam logic [11:0] REG_DATA = 12'h008;
  localparam logic [11:0] REG_LEVEL = 12'h00C;
  localparam logic [11:0] REG_LIMIT = 12'h010;
  localparam logic [11:0] REG_RIS = 12'h014;
  localparam logic [11:0] REG_IM = 12'h018;
  localparam logic [11:0] REG_MIS = 12'h01C;
  localparam logic [11:0] REG_STAT = 12'h020;
  // Frame formats
  localparam logic [1:0] FMT_STANDARD = 2'h0;
  localparam logic [1:0] FMT_LEFT_JUSTIFIED = 2'h1;
  localparam logic [1:0] FMT_RIGHT_JUSTIFIED = 2'h2;
  // Packing modes
  localparam logic [1:0] MODE_DUAL = 2'h0;
  localparam logic [1:0] MODE_COMPACT16 = 2'h1;
  localparam logic [1:0] MODE_COMPACT8 = 2'h2;
  localparam logic [1:0] MODE_MONO = 2'h3;
  // Size codes
  localparam logic [2:0] SIZE_32 = 3'h0;
  localparam logic [2:0] SIZE_24 = 3'h1;
  localparam logic [2:0] SIZE_20 = 3'h2;
  localparam logic [2:0] SIZE_16 = 3'h3;
  localparam logic [2:0] SIZE_8 = 3'h4;
  // Field positions and reset values
  localparam int CFG_W = 13;
  localparam logic [CFG_W-1:0] CFG_RST = 13'h0000;
  localparam logic [4:0] LIMIT_RST = 5'h10;
  localparam int FLAG_ERR = 0;
  localparam int FLAG_REQ = 1;
  // FIFO geometry: pairs held, level counts two per pair
  localparam int FIFO_PAIRS = 8;
  localparam logic [3:0] FIFO_FULL_PAIRS = 4'h8;
  // Clock generation
  localparam logic [3:0] MCLK_INT_DIV = 4'h1;
  localparam logic [3:0] SCLK_HALF_TICKS = 4'h1;
  localparam logic [5:0] BITCNT_MAX = 6'h3F;

  // Receive configuration word
  typedef struct packed {
    logic mclk_ext;
    logic [2:0] wire_size;
    logic [2:0] sample_size;
    logic master;
    logic [1:0] mode;
    logic sclk_invert;
    logic [1:0] fmt;
  } asr_cfg_t;

  // One stored left-right pair
  typedef struct packed {
    logic [31:0] right;
    logic [31:0] left;
  } asr_pair_t;

  // Synchronised link pins
  typedef struct packed {
    logic mclk;
    logic sclk;
    logic lrclk;
    logic sd;
  } asr_link_t;

  // Bits per size code
  function automatic logic [5:0] size_bits(input logic [2:0] code);
    case (code)
      SIZE_24: size_bits = 6'h18;
      SIZE_20: size_bits = 6'h14;
      SIZE_16: size_bits = 6'h10;
      SIZE_8: size_bits = 6'h08;
      default: size_bits = 6'h20;
    endcase
  endfunction
endpackage

// >>> src/asr_sync.sv
// Purpose: two-stage synchroniser for the link pins
// Assumes: inputs are asynchronous to CLK_SYS_I
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module asr_sync
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire asr_link_t pin_i,
  output asr_link_t sync_o
);
  asr_link_t meta;

  // Two flip-flops per pin
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= pin_i;
      sync_o <= meta;
    end
  end
endmodule

// >>> src/asr_top.sv
// Purpose: audio serial receiver with pair FIFO behind an APB slave
// Assumes: link pins asynchronous, sampled by CLK_SYS_I at 25 MHz
// Notes: level counts two per stored pair, less one after a half read
// Overview of operation
// - Standard, left-justified and right-justified framing are selectable.
// - A setting inverts the bit clock edge used for sampling.
// - Dual, 16-bit compact, 8-bit compact and mono packing exist.
// - The block either drives both link clocks or follows them.
// - Bits kept per sample: 32, 24, 20, 16 or 8.
// - Bits per wire word: 32, 24, 20, 16 or 8, independently.
// - Dual mode reads alternate channels, left first.
// - 16-bit compact read: left in low half, right in high half.
// - 8-bit compact read: left bits 7..0, right 15..8, rest zero.
// - Mono reads return one sample each.
// - Empty is visible; a read when empty removes nothing.
// - Level adds two per pair, and two per mono sample.
// - Level is readable, normally even, from 0 to 16.
// - A left read without its right makes the level odd.
// - While disabled nothing is captured; an enable bit controls this.
// - The service threshold reads back as written.
// - A service request stands while level exceeds the threshold.
// - Error and request flags are maskable, read raw and masked.
// - Master clock source is internal or an external pin.
`timescale 1ns/1ps
module asr_top
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Serial link
  input wire logic MCLK_EXT_I,
  input wire logic SD_I,
  input wire logic SCLK_I,
  output logic SCLK_O,
  output logic SCLK_OE_N_O,
  input wire logic LRCLK_I,
  output logic LRCLK_O,
  output logic LRCLK_OE_N_O,
  // Service request for DMA
  output logic RX_REQ_O
);
  typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_RUN} asr_state_t;

  asr_cfg_t cfg;
  logic rx_enable;
  logic [4:0] limit;
  logic [1:0] irq_mask;
  logic rx_error_flag;
  logic rx_service_request_flag;
  asr_link_t link_pins;
  asr_link_t link;
  logic gen_sclk;
  logic gen_lrclk;
  logic [3:0] mdiv;
  logic mclk_prev;
  logic mclk_tick;
  logic sclk_prev;
  logic eff_sclk;
  logic eff_lrclk;
  logic bit_edge;
  asr_state_t state;
  logic lr_prev;
  logic [5:0] cnt;
  logic [31:0] shreg;
  logic take;
  logic [31:0] word;
  logic [31:0] sample;
  logic [31:0] left_hold;
  logic have_left;
  logic push_q;
  asr_pair_t push_data;
  asr_pair_t fifo [FIFO_PAIRS];
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  logic [3:0] npairs;
  logic half;
  logic empty;
  logic full;
  logic [4:0] level;
  asr_pair_t head;
  logic [31:0] data_word;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic pop;
  logic err_set;
  logic err_clr;
  logic mapped;
  logic [31:0] next_rdata;
  logic [5:0] wire_bits;
  logic [5:0] smp_bits;

  // Mask of the low n bits of a word
  function automatic logic [31:0] low_mask(input logic [5:0] n);
    low_mask = (n >= 6'h20) ? 32'hFFFFFFFF : ((32'h00000001 << n) - 32'h00000001);
  endfunction

  // Re-size a wire word to the kept sample size, MSB aligned
  function automatic logic [31:0] fit(input logic [31:0] w, input logic [5:0] wb, input logic [5:0] sb);
    if (sb <= wb) begin
      fit = w >> (wb - sb);
    end else begin
      fit = (w << (sb - wb)) & low_mask(sb);
    end
  endfunction

  assign wire_bits = size_bits(cfg.wire_size);
  assign smp_bits = size_bits(cfg.sample_size);

  // Pin synchroniser
  assign link_pins = '{mclk: MCLK_EXT_I, sclk: SCLK_I, lrclk: LRCLK_I, sd: SD_I};

  asr_sync u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .pin_i(link_pins),
    .sync_o(link)
  );

  // Master clock tick from the internal divider or the external pin
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mdiv <= '0;
      mclk_prev <= 1'b0;
    end else begin
      mdiv <= (mdiv == MCLK_INT_DIV - 4'h1) ? 4'h0 : mdiv + 4'h1;
      mclk_prev <= link.mclk;
    end
  end

  assign mclk_tick = cfg.mclk_ext ? (link.mclk & ~mclk_prev) : (mdiv == MCLK_INT_DIV - 4'h1);

  // Clock generation in master mode
  asr_clkgen u_clkgen (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .tick_i(mclk_tick),
    .run_i(rx_enable & cfg.master),
    .wire_bits_i(wire_bits),
    .sclk_o(gen_sclk),
    .lrclk_o(gen_lrclk)
  );

  // Pin drivers: enables low while driving
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SCLK_OE_N_O <= 1'b1;
      LRCLK_OE_N_O <= 1'b1;
      SCLK_O <= 1'b0;
      LRCLK_O <= 1'b0;
    end else begin
      SCLK_OE_N_O <= ~(cfg.master & rx_enable);
      LRCLK_OE_N_O <= ~(cfg.master & rx_enable);
      // Gated with the enable term so a released pin never shows a high clock
      SCLK_O <= gen_sclk & cfg.master & rx_enable;
      LRCLK_O <= gen_lrclk & cfg.master & rx_enable;
    end
  end

  // Sampling clock and its active edge
  assign eff_sclk = (cfg.master ? gen_sclk : link.sclk) ^ cfg.sclk_invert;
  assign eff_lrclk = cfg.master ? gen_lrclk : link.lrclk;
  assign bit_edge = eff_sclk & ~sclk_prev;

  // Which bits of a half frame belong to the word
  always_comb begin
    take = 1'b0;
    // A standard frame as long as the word carries its last bit in the word clock change slot
    word = (((cfg.fmt == FMT_STANDARD) && (cnt == wire_bits)) ? {shreg[30:0], link.sd} : shreg)
      & low_mask(wire_bits);
    unique case (cfg.fmt)
      FMT_STANDARD: take = (eff_lrclk != lr_prev) ? 1'b0 : (cnt >= 6'h01 && cnt <= wire_bits);
      FMT_LEFT_JUSTIFIED: take = (eff_lrclk != lr_prev) ? 1'b1 : (cnt < wire_bits);
      default: take = 1'b1;
    endcase
    sample = fit(word, wire_bits, smp_bits);
  end

  // Deserialiser: finalises a channel at each word clock change
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= ST_IDLE;
      sclk_prev <= 1'b0;
      lr_prev <= 1'b0;
      cnt <= '0;
      shreg <= '0;
      left_hold <= '0;
      have_left <= 1'b0;
      push_q <= 1'b0;
      push_data <= '0;
    end else begin
      sclk_prev <= eff_sclk;
      push_q <= 1'b0;
      if (!rx_enable) begin
        state <= ST_IDLE;
        have_left <= 1'b0;
      end else if (bit_edge) begin
        unique case (state)
          ST_IDLE: begin
            lr_prev <= eff_lrclk;
            state <= ST_ALIGN;
          end
          ST_ALIGN: begin
            if (eff_lrclk != lr_prev) begin
              state <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (eff_lrclk != lr_prev) begin
              if ((cfg.fmt == FMT_STANDARD) ? ~lr_prev : lr_prev) begin
                left_hold <= sample;
                have_left <= (cfg.mode != MODE_MONO);
                if (cfg.mode == MODE_MONO) begin
                  push_q <= 1'b1;
                  push_data <= '{right: 32'h00000000, left: sample};
                end
              end else if (have_left) begin
                push_q <= 1'b1;
                push_data <= '{right: sample, left: left_hold};
                have_left <= 1'b0;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
        if (eff_lrclk != lr_prev) begin
          lr_prev <= eff_lrclk;
          cnt <= 6'h01;
          shreg <= take ? {31'h00000000, link.sd} : 32'h00000000;
        end else begin
          cnt <= (cnt == BITCNT_MAX) ? cnt : cnt + 6'h01;
          shreg <= take ? {shreg[30:0], link.sd} : shreg;
        end
      end
    end
  end

  // FIFO status and the word presented to a read
  assign empty = (npairs == 4'h0);
  assign full = (npairs == FIFO_FULL_PAIRS);
  assign level = {npairs, 1'b0} - {4'h0, half};
  assign head = fifo[rd_ptr];

  always_comb begin
    data_word = 32'h00000000;
    if (!empty) begin
      unique case (cfg.mode)
        MODE_DUAL: data_word = half ? head.right : head.left;
        MODE_COMPACT16: data_word = {head.right[15:0], head.left[15:0]};
        MODE_COMPACT8: data_word = {16'h0000, head.right[7:0], head.left[7:0]};
        default: data_word = head.left;
      endcase
    end
  end

  // APB access decode
  assign acc = PSEL_I & PENABLE_I & PREADY_O;
  assign wr_acc = acc & PWRITE_I & mapped;
  assign rd_acc = acc & ~PWRITE_I & mapped;
  assign pop = rd_acc & (PADDR_I == REG_DATA) & ~empty & ((cfg.mode != MODE_DUAL) | half);

  // Pair storage with write and read pointers
  always_ff @(posedge CLK_SYS_I) begin
    if (push_q && !full) begin
      fifo[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      npairs <= '0;
      half <= 1'b0;
    end else begin
      if (push_q && !full) begin
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 3'h1;
      end
      npairs <= npairs + {3'h0, push_q & ~full} - {3'h0, pop};
      if (rd_acc && PADDR_I == REG_DATA && !empty && cfg.mode == MODE_DUAL) begin
        half <= ~half;
      end else if (cfg.mode != MODE_DUAL) begin
        half <= 1'b0;
      end
    end
  end

  // Flags: error is sticky, request follows the level
  assign err_set = push_q & full;
  assign err_clr = wr_acc & (PADDR_I == REG_RIS) & PWDATA_I[FLAG_ERR];

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_error_flag <= 1'b0;
      rx_service_request_flag <= 1'b0;
      RX_REQ_O <= 1'b0;
    end else begin
      rx_error_flag <= err_set | (rx_error_flag & ~err_clr);
      rx_service_request_flag <= (level > limit);
      RX_REQ_O <= (level > limit) & irq_mask[FLAG_REQ];
    end
  end

  // Control registers written by software
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg <= CFG_RST;
      rx_enable <= 1'b0;
      limit <= LIMIT_RST;
      irq_mask <= '0;
    end else if (wr_acc) begin
      unique case (PADDR_I)
        REG_CFG: cfg <= PWDATA_I[CFG_W-1:0];
        REG_CTRL: rx_enable <= PWDATA_I[0];
        REG_LIMIT: limit <= PWDATA_I[4:0];
        REG_IM: irq_mask <= PWDATA_I[1:0];
        default: ;
      endcase
    end
  end

  // Read multiplexer and address map
  always_comb begin
    mapped = 1'b1;
    next_rdata = 32'h00000000;
    unique case (PADDR_I)
      REG_CFG: next_rdata = {19'h00000, cfg};
      REG_CTRL: next_rdata = {31'h00000000, rx_enable};
      REG_DATA: next_rdata = data_word;
      REG_LEVEL: next_rdata = {27'h0000000, level};
      REG_LIMIT: next_rdata = {27'h0000000, limit};
      REG_RIS: next_rdata = {30'h00000000, rx_service_request_flag, rx_error_flag};
      REG_IM: next_rdata = {30'h00000000, irq_mask};
      REG_MIS: next_rdata = {30'h00000000, {rx_service_request_flag, rx_error_flag} & irq_mask};
      REG_STAT: next_rdata = {30'h00000000, full, empty};
      default: mapped = 1'b0;
    endcase
  end

  // APB handshake: one wait cycle, read data captured with ready
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= '0;
    end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= ~mapped;
      PRDATA_O <= PWRITE_I ? 32'h00000000 : next_rdata;
    end else begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end
endmodule
